// ### flash_table_access.sv
// table access unit between the core's table instructions and program flash
// assumes one clock, an apb master, a flash word read port with one-cycle
// latency and an external programming timer that answers with progDone
`timescale 1ns/1ps
`include "fta_defs.svh"
module flash_table_access import fta_pkg::*; #(
  parameter int ADDR_W = 12
) (
  input wire logic ref_clk,
  input wire logic resetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // core table instruction port
  input wire logic instrValid,
  input wire logic instrStore,
  input wire logic [1:0] instrMode,
  output logic instrReady,
  output logic coreStall,
  // flash word read port
  output logic [21:0] flashAddr,
  output logic flashRead,
  input wire logic [15:0] flashWord,
  // programming timer side
  output logic progStart,
  output logic progErase,
  output logic progPgm,
  output logic progCfg,
  output logic [21:0] progAddr,
  output logic [63:0] progData,
  input wire logic progDone,
  input wire logic progAbort,
  output logic irq
);
  if (ADDR_W < 5) begin : g_bad_addr
    $error("ADDR_W too narrow for the register map");
  end

  fta_state_t state, next_state;
  logic [7:0] latch, next_latch;
  logic [21:0] ptr, next_ptr;
  logic [7:0] ctrl, next_ctrl;
  logic [2:0] istat, next_istat;
  logic [2:0] imask, next_imask;
  logic [7:0] hold [8];
  logic [7:0] next_hold [8];
  logic [21:0] next_flashAddr;
  logic next_flashRead;
  logic next_progStart, next_progErase, next_progPgm, next_progCfg;
  logic [21:0] next_progAddr;
  logic [31:0] next_prdata;
  logic wrAcc, rdAcc, hit;
  logic [21:0] ptrInc, ptrDec, effAddr;
  logic [2:0] evt;

  // zero wait states; decode error for unmapped words
  assign pready = 1'b1;
  assign wrAcc = psel & penable & pwrite;
  assign rdAcc = psel & ~penable & ~pwrite;
  always_comb begin
    case (paddr)
      `FTA_OFF_LATCH, `FTA_OFF_PTRU, `FTA_OFF_PTRH, `FTA_OFF_PTRL,
      `FTA_OFF_CTRL, `FTA_OFF_ISTAT, `FTA_OFF_IMASK: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  end
  assign pslverr = psel & penable & ~hit;

  // increments wrap inside the low 21 bits so the id space stays selected
  assign ptrInc = {ptr[21], ptr[20:0] + 21'h0_0001};
  assign ptrDec = {ptr[21], ptr[20:0] - 21'h0_0001};
  assign effAddr = (fta_ptr_mode_t'(instrMode) == FTA_PTR_PREINC) ? ptrInc : ptr;
  assign instrReady = (state == FTA_IDLE);
  assign coreStall = (state == FTA_LONG);
  assign irq = |(istat & imask);
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      progData[i*8 +: 8] = hold[i];
    end
  end

  // next state of the whole unit
  always_comb begin
    next_state = state;
    next_latch = latch;
    next_ptr = ptr;
    next_ctrl = ctrl;
    next_istat = istat;
    next_imask = imask;
    next_hold = hold;
    next_flashAddr = flashAddr;
    next_flashRead = 1'b0;
    next_progStart = 1'b0;
    next_progErase = progErase;
    next_progPgm = progPgm;
    next_progCfg = progCfg;
    next_progAddr = progAddr;
    next_prdata = 32'h0000_0000;
    evt = 3'h0;
    // register writes; software may set start and fetch but never clear them
    if (wrAcc) begin
      case (paddr)
        `FTA_OFF_LATCH: next_latch = pwdata[7:0];
        `FTA_OFF_PTRU: next_ptr[21:16] = pwdata[5:0];
        `FTA_OFF_PTRH: next_ptr[15:8] = pwdata[7:0];
        `FTA_OFF_PTRL: next_ptr[7:0] = pwdata[7:0];
        `FTA_OFF_CTRL: begin
          next_ctrl[`FTA_CTL_PGM] = pwdata[`FTA_CTL_PGM];
          next_ctrl[`FTA_CTL_CFGS] = pwdata[`FTA_CTL_CFGS];
          next_ctrl[`FTA_CTL_ERASE] = pwdata[`FTA_CTL_ERASE];
          next_ctrl[`FTA_CTL_ERR] = pwdata[`FTA_CTL_ERR];
          next_ctrl[`FTA_CTL_WREN] = pwdata[`FTA_CTL_WREN];
          // start is ignored unless writes are enabled and the unit is idle
          if (pwdata[`FTA_CTL_START] && pwdata[`FTA_CTL_WREN] && state == FTA_IDLE) begin
            next_ctrl[`FTA_CTL_START] = 1'b1;
            next_state = FTA_LONG;
            next_progStart = 1'b1;
            next_progErase = pwdata[`FTA_CTL_ERASE];
            next_progPgm = pwdata[`FTA_CTL_PGM];
            next_progCfg = pwdata[`FTA_CTL_CFGS];
            // block base from the pointer; low offset bits are ignored
            if (pwdata[`FTA_CTL_ERASE]) begin
              next_progAddr = {ptr[21:`FTA_EBLK_LSB], 6'h00};
            end else begin
              next_progAddr = {ptr[21:`FTA_WBLK_LSB], 3'h0};
            end
          end else if (pwdata[`FTA_CTL_FETCH] && state == FTA_IDLE) begin
            next_ctrl[`FTA_CTL_FETCH] = 1'b1;
            next_flashAddr = ptr;
            next_flashRead = 1'b1;
            next_state = FTA_FETCH;
          end
        end
        `FTA_OFF_ISTAT: next_istat = istat & ~pwdata[2:0];
        `FTA_OFF_IMASK: next_imask = pwdata[2:0];
        default: ;
      endcase
    end
    // table instructions; they win over a register write in the same cycle unless that write launches a start or a fetch
    if (instrValid && state == FTA_IDLE && next_state == FTA_IDLE) begin
      case (fta_ptr_mode_t'(instrMode))
        FTA_PTR_KEEP: next_ptr = ptr;
        FTA_PTR_POSTINC: next_ptr = ptrInc;
        FTA_PTR_POSTDEC: next_ptr = ptrDec;
        FTA_PTR_PREINC: next_ptr = ptrInc;
        default: next_ptr = ptr;
      endcase
      if (instrStore) begin
        // short write: holding register only, flash untouched
        next_hold[effAddr[2:0]] = latch;
      end else begin
        next_flashAddr = effAddr;
        next_flashRead = 1'b1;
        next_state = FTA_FETCH;
      end
    end
    case (state)
      FTA_FETCH: begin
        // the addressed word is back; bit 0 picks its byte
        next_latch = flashAddr[0] ? flashWord[15:8] : flashWord[7:0];
        next_ctrl[`FTA_CTL_FETCH] = 1'b0;
        next_state = FTA_IDLE;
        evt[`FTA_IRQ_FETCH] = 1'b1;
      end
      FTA_LONG: begin
        if (progAbort) begin
          next_ctrl[`FTA_CTL_ERR] = 1'b1;
          next_ctrl[`FTA_CTL_START] = 1'b0;
          next_state = FTA_IDLE;
          evt[`FTA_IRQ_ERR] = 1'b1;
        end else if (progDone) begin
          next_ctrl[`FTA_CTL_START] = 1'b0;
          if (progErase) begin
            next_ctrl[`FTA_CTL_ERASE] = 1'b0;
          end
          next_state = FTA_IDLE;
          evt[`FTA_IRQ_DONE] = 1'b1;
        end
      end
      FTA_IDLE: ;
      default: next_state = FTA_IDLE;
    endcase
    // sticky events: a set in the clearing cycle wins
    next_istat = next_istat | evt;
    // read data taken in the setup cycle, presented in the access cycle
    if (rdAcc) begin
      case (paddr)
        `FTA_OFF_LATCH: next_prdata = {24'h00_0000, latch};
        `FTA_OFF_PTRU: next_prdata = {26'h000_0000, ptr[21:16]};
        `FTA_OFF_PTRH: next_prdata = {24'h00_0000, ptr[15:8]};
        `FTA_OFF_PTRL: next_prdata = {24'h00_0000, ptr[7:0]};
        `FTA_OFF_CTRL: next_prdata = {24'h00_0000, ctrl[7:6], 1'b0, ctrl[4:0]};
        `FTA_OFF_ISTAT: next_prdata = {29'h0000_0000, istat};
        `FTA_OFF_IMASK: next_prdata = {29'h0000_0000, imask};
        default: next_prdata = 32'h0000_0000;
      endcase
    end
  end

  // registers only; holding contents are cleared too, flash retains its own copy
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state <= FTA_IDLE;
      latch <= `FTA_RST_BYTE;
      ptr <= `FTA_RST_PTR;
      ctrl <= `FTA_RST_BYTE;
      istat <= `FTA_RST_IRQ;
      imask <= `FTA_RST_IRQ;
      for (int i = 0; i < 8; i++) begin
        hold[i] <= `FTA_RST_BYTE;
      end
      flashAddr <= `FTA_RST_PTR;
      flashRead <= 1'b0;
      progStart <= 1'b0;
      progErase <= 1'b0;
      progPgm <= 1'b0;
      progCfg <= 1'b0;
      progAddr <= `FTA_RST_PTR;
      prdata <= 32'h0000_0000;
    end else begin
      state <= next_state;
      latch <= next_latch;
      ptr <= next_ptr;
      ctrl <= next_ctrl;
      istat <= next_istat;
      imask <= next_imask;
      hold <= next_hold;
      flashAddr <= next_flashAddr;
      flashRead <= next_flashRead;
      progStart <= next_progStart;
      progErase <= next_progErase;
      progPgm <= next_progPgm;
      progCfg <= next_progCfg;
      progAddr <= next_progAddr;
      prdata <= next_prdata;
    end
  end

  // checks
  sequence s_long_entered;
    progStart && state == FTA_LONG;
  endsequence
  sequence s_long_left;
    state == FTA_IDLE && !ctrl[`FTA_CTL_START];
  endsequence

  property p_start_launch;
    @(posedge ref_clk) disable iff (!resetn)
      $rose(ctrl[`FTA_CTL_START]) |-> s_long_entered;
  endproperty
  a_start_launch: assert property (p_start_launch) else $error("start did not launch");

  property p_start_held;
    @(posedge ref_clk) disable iff (!resetn)
      (ctrl[`FTA_CTL_START] && !progDone && !progAbort) |=> ctrl[`FTA_CTL_START];
  endproperty
  a_start_held: assert property (p_start_held) else $error("start fell early");

  property p_start_end;
    @(posedge ref_clk) disable iff (!resetn)
      (state == FTA_LONG && progDone) |=> s_long_left;
  endproperty
  a_start_end: assert property (p_start_end) else $error("start not cleared at end");

  property p_fetch_self_clear;
    @(posedge ref_clk) disable iff (!resetn)
      $rose(ctrl[`FTA_CTL_FETCH]) |=> !ctrl[`FTA_CTL_FETCH] && state == FTA_IDLE;
  endproperty
  a_fetch_self_clear: assert property (p_fetch_self_clear) else $error("fetch bit stuck");

  property p_top_bit_kept;
    @(posedge ref_clk) disable iff (!resetn)
      (instrValid && instrReady && !wrAcc) |=> ptr[21] == $past(ptr[21]);
  endproperty
  a_top_bit_kept: assert property (p_top_bit_kept) else $error("pointer top bit moved");

  property p_post_dec;
    @(posedge ref_clk) disable iff (!resetn)
      (instrValid && instrReady && !wrAcc && instrMode == 2'h2)
      |=> ptr[20:0] == $past(ptr[20:0]) - 21'h0_0001;
  endproperty
  a_post_dec: assert property (p_post_dec) else $error("post-decrement wrong");

  property p_byte_select;
    @(posedge ref_clk) disable iff (!resetn)
      (state == FTA_FETCH) |=> latch == ($past(flashAddr[0]) ? $past(flashWord[15:8])
                                                              : $past(flashWord[7:0]));
  endproperty
  a_byte_select: assert property (p_byte_select) else $error("wrong byte latched");

  property p_store_hold;
    @(posedge ref_clk) disable iff (!resetn)
      (instrValid && instrReady && instrStore && !wrAcc)
      |=> hold[$past(effAddr[2:0])] == $past(latch) && !progStart;
  endproperty
  a_store_hold: assert property (p_store_hold) else $error("store missed holding");

  property p_block_align;
    @(posedge ref_clk) disable iff (!resetn)
      progStart |-> (progErase ? progAddr[5:0] == 6'h00 : progAddr[2:0] == 3'h0);
  endproperty
  a_block_align: assert property (p_block_align) else $error("block not aligned");

  property p_erase_sel_clear;
    @(posedge ref_clk) disable iff (!resetn)
      (state == FTA_LONG && progErase && progDone && !progAbort)
      |=> !ctrl[`FTA_CTL_ERASE];
  endproperty
  a_erase_sel_clear: assert property (p_erase_sel_clear) else $error("erase select kept");

  property p_abort_flag;
    @(posedge ref_clk) disable iff (!resetn)
      (state == FTA_LONG && progAbort) |=> ctrl[`FTA_CTL_ERR] && istat[`FTA_IRQ_ERR];
  endproperty
  a_abort_flag: assert property (p_abort_flag) else $error("abort not flagged");

  property p_stall;
    @(posedge ref_clk) disable iff (!resetn)
      s_long_entered |-> coreStall && !instrReady;
  endproperty
  a_stall: assert property (p_stall) else $error("core not stalled");
endmodule

// ### fta_defs.svh
// constants of the flash table access unit: offsets, bit positions, reset values
// assumes inclusion from the package, the design file and the testbench
`ifndef FTA_DEFS_SVH
`define FTA_DEFS_SVH
// apb byte offsets, one aligned word each
`define FTA_OFF_LATCH 12'h000
`define FTA_OFF_PTRU 12'h004
`define FTA_OFF_PTRH 12'h008
`define FTA_OFF_PTRL 12'h00C
`define FTA_OFF_CTRL 12'h010
`define FTA_OFF_ISTAT 12'h014
`define FTA_OFF_IMASK 12'h018
// control register bit positions
`define FTA_CTL_FETCH 0
`define FTA_CTL_START 1
`define FTA_CTL_WREN 2
`define FTA_CTL_ERR 3
`define FTA_CTL_ERASE 4
`define FTA_CTL_CFGS 6
`define FTA_CTL_PGM 7
// interrupt status bit positions
`define FTA_IRQ_DONE 0
`define FTA_IRQ_ERR 1
`define FTA_IRQ_FETCH 2
// reset values
`define FTA_RST_BYTE 8'h00
`define FTA_RST_PTR 22'h00_0000
`define FTA_RST_IRQ 3'h0
// pointer slices: block alignment widths
`define FTA_WBLK_LSB 3
`define FTA_EBLK_LSB 6
`endif

// ### fta_pkg.sv
// types of the flash table access unit
// assumes fta_defs.svh is on the include path
package fta_pkg;
  `include "fta_defs.svh"
  // pointer update variants of a table instruction
  typedef enum logic [1:0] {
    FTA_PTR_KEEP,
    FTA_PTR_POSTINC,
    FTA_PTR_POSTDEC,
    FTA_PTR_PREINC
  } fta_ptr_mode_t;
  // unit sequencing
  typedef enum logic [1:0] {
    FTA_IDLE,
    FTA_FETCH,
    FTA_LONG
  } fta_state_t;
endpackage

// ### fta_flash_model.sv
// partner model: program flash word port and self-timed programming timer
// assumes the unit pulses flashRead one cycle and progStart once per long cycle
`timescale 1ns/1ps
module fta_flash_model (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [21:0] flashAddr,
  input wire logic flashRead,
  output logic [15:0] flashWord,
  input wire logic progStart,
  input wire logic [7:0] dly,
  input wire logic abortNext,
  output logic progDone,
  output logic progAbort
);
  logic [15:0] lastWord;
  logic [15:0] memWord;
  logic [7:0] cnt;
  logic busy;
  // word mixes the top pointer bit in, so a dropped bit shows in the byte
  assign memWord = {8'hC3 ^ flashAddr[8:1], flashAddr[8:1] ^ {flashAddr[21], flashAddr[17:11]}};
  // released port shows the inverse of the last word, never a stale copy
  assign flashWord = flashRead ? memWord : ~lastWord;
  // timer ends each long cycle dly+1 cycles after it sees progStart, done or aborted
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      lastWord <= 16'h0000;
      cnt <= 8'h00;
      busy <= 1'b0;
      progDone <= 1'b0;
      progAbort <= 1'b0;
    end else begin
      progDone <= 1'b0;
      progAbort <= 1'b0;
      if (flashRead) begin
        lastWord <= memWord;
      end
      if (progStart) begin
        busy <= 1'b1;
        cnt <= dly;
      end else if (busy && cnt == 8'h00) begin
        busy <= 1'b0;
        progAbort <= abortNext;
        progDone <= !abortNext;
      end else if (busy) begin
        cnt <= cnt - 8'h01;
      end
    end
  end
endmodule

// ### testbench.sv
// self-checking bench of the flash table access unit
// assumes the unit, its defines header and the flash and timer model
`timescale 1ns/1ps
`include "fta_defs.svh"
module testbench;
  localparam logic [11:0] LAT = `FTA_OFF_LATCH;
  localparam logic [11:0] CTL = `FTA_OFF_CTRL;
  localparam logic [11:0] IST = `FTA_OFF_ISTAT;
  logic ref_clk, resetn, psel, penable, pwrite, pready, pslverr, err, rdy;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic instrValid, instrStore, instrReady, coreStall, flashRead, irq;
  logic [1:0] instrMode;
  logic [21:0] flashAddr, progAddr;
  logic [15:0] flashWord;
  logic progStart, progErase, progPgm, progCfg, progDone, progAbort, abortNext;
  logic [63:0] progData;
  logic [7:0] dly;
  int n_mismatch = 0;
  int total_checks = 0;
  int nStart = 0;
  typedef struct {logic [21:0] ptr; logic [1:0] mode; logic [21:0] eff, after;} fta_row_t;
  // pointer, variant, fetched address, pointer after; wrap and top-bit rows last
  fta_row_t rows [7] = '{
    '{22'h00_0010, 2'h0, 22'h00_0010, 22'h00_0010},
    '{22'h00_0011, 2'h1, 22'h00_0011, 22'h00_0012},
    '{22'h00_0020, 2'h2, 22'h00_0020, 22'h00_001F},
    '{22'h00_0030, 2'h3, 22'h00_0031, 22'h00_0031},
    '{22'h1F_FFFF, 2'h1, 22'h1F_FFFF, 22'h00_0000},
    '{22'h20_0000, 2'h2, 22'h20_0000, 22'h3F_FFFF},
    '{22'h3F_FFFF, 2'h3, 22'h20_0000, 22'h20_0000}};
  flash_table_access #(.ADDR_W(12)) dut_u (.ref_clk(ref_clk), .resetn(resetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .instrValid(instrValid),
    .instrStore(instrStore), .instrMode(instrMode), .instrReady(instrReady),
    .coreStall(coreStall), .flashAddr(flashAddr), .flashRead(flashRead),
    .flashWord(flashWord), .progStart(progStart), .progErase(progErase),
    .progPgm(progPgm), .progCfg(progCfg), .progAddr(progAddr), .progData(progData),
    .progDone(progDone), .progAbort(progAbort), .irq(irq));
  fta_flash_model model_u (.ref_clk(ref_clk), .resetn(resetn), .flashAddr(flashAddr),
    .flashRead(flashRead), .flashWord(flashWord), .progStart(progStart), .dly(dly),
    .abortNext(abortNext), .progDone(progDone), .progAbort(progAbort));
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  // a start pulse is counted so stray launches show up
  always @(posedge ref_clk) if (progStart === 1'b1) nStart++;
  task automatic end_sim();
    if (n_mismatch == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
    total_checks++;
    if (got !== exp) begin
      $display("FAIL %s expected %h seen %h", nm, exp, got);
      n_mismatch++;
    end
  endtask
  // apb transfer; answer taken at the rising edge that sees pready high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      rdy = pready;
      rd = prdata;
      err = pslverr;
      n++;
    end while (rdy !== 1'b1 && n < 50);
    if (rdy !== 1'b1) n_mismatch++;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(nm, exp, rd);
  endtask
  task automatic setPtr(input logic [21:0] p);
    apb(1'b1, `FTA_OFF_PTRU, {26'h0, p[21:16]});
    apb(1'b1, `FTA_OFF_PTRH, {24'h0, p[15:8]});
    apb(1'b1, `FTA_OFF_PTRL, {24'h0, p[7:0]});
  endtask
  task automatic chkPtr(input logic [21:0] p);
    rdc("ptr upper", `FTA_OFF_PTRU, {26'h0, p[21:16]});
    rdc("ptr high", `FTA_OFF_PTRH, {24'h0, p[15:8]});
    rdc("ptr low", `FTA_OFF_PTRL, {24'h0, p[7:0]});
  endtask
  // one table instruction; extra edge lets a fetch land in the latch
  task automatic ins(input logic st, input logic [1:0] m);
    int n = 0;
    @(posedge ref_clk);
    instrValid <= 1'b1;
    instrStore <= st;
    instrMode <= m;
    do begin
      @(posedge ref_clk);
      rdy = instrReady;
      n++;
    end while (rdy !== 1'b1 && n < 50);
    if (rdy !== 1'b1) n_mismatch++;
    instrValid <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic waitIdle();
    int n = 0;
    do begin
      @(negedge ref_clk);
      n++;
    end while (coreStall !== 1'b0 && n < 400);
    if (coreStall !== 1'b0) n_mismatch++;
  endtask
  function automatic logic [7:0] expByte(input logic [21:0] a);
    return a[0] ? 8'hC3 ^ a[8:1] : a[8:1] ^ {a[21], a[17:11]};
  endfunction
  // hang guard, far beyond the few hundred cycles the run needs
  initial begin
    #500_000;
    n_mismatch++;
    end_sim();
  end
  initial begin
    {resetn, psel, penable, pwrite, instrValid, instrStore, abortNext} = 7'h00;
    {paddr, pwdata, instrMode, dly} = 54'h0;
    repeat (12) @(posedge ref_clk);
    resetn <= 1'b1;
    for (int i = 0; i < 7; i++) rdc("reset value", 12'(4 * i), 32'h0000_0000);
    apb(1'b0, 12'h01C, 32'h0000_0000);
    chk("unmapped error", 1, err);
    apb(1'b1, LAT, 32'h0000_00A5);
    rdc("latch", LAT, 32'h0000_00A5);
    for (int i = 0; i < 7; i++) begin
      setPtr(rows[i].ptr);
      ins(1'b0, rows[i].mode);
      rdc("fetched byte", LAT, {24'h0, expByte(rows[i].eff)});
      chkPtr(rows[i].after);
    end
    rdc("fetch status", IST, 32'h0000_0004);
    apb(1'b1, IST, 32'h0000_0007);
    apb(1'b1, `FTA_OFF_IMASK, 32'h0000_0001);
    // stores from an unaligned pointer wrap around the holding index
    setPtr(22'h01_2343);
    for (int k = 0; k < 8; k++) begin
      apb(1'b1, LAT, 32'(8'h10 + k));
      ins(1'b1, 2'h1);
    end
    chk("no launch", 0, nStart);
    chkPtr(22'h01_234B);
    for (int j = 0; j < 8; j++) chk("holding", 8'h10 + (j + 5) % 8, progData[8*j +: 8]);
    dly <= 8'h40;
    apb(1'b1, CTL, 32'h0000_0086);
    @(negedge ref_clk);
    chk("stall", 1, coreStall);
    chk("ready", 0, instrReady);
    chk("launch", 1, progStart);
    chk("pgm level", 1, progPgm);
    chk("write block", 22'h01_2348, progAddr);
    chk("erase level", 0, progErase);
    apb(1'b1, CTL, 32'h0000_0084);
    rdc("start held", CTL, 32'h0000_0086);
    waitIdle();
    rdc("start cleared", CTL, 32'h0000_0084);
    chk("irq done", 1, irq);
    apb(1'b1, IST, 32'h0000_0007);
    @(negedge ref_clk);
    chk("irq cleared", 0, irq);
    // prompt timer this time, erase of an unaligned row address
    dly <= 8'h02;
    setPtr(22'h01_2345);
    apb(1'b1, CTL, 32'h0000_0096);
    @(negedge ref_clk);
    chk("erase block", 22'h01_2340, progAddr);
    chk("erase level", 1, progErase);
    waitIdle();
    rdc("erase select", CTL, 32'h0000_0084);
    apb(1'b1, IST, 32'h0000_0007);
    // aborted write of the config space; select bits survive the abort
    abortNext <= 1'b1;
    apb(1'b1, CTL, 32'h0000_00C6);
    @(negedge ref_clk);
    chk("cfg level", 1, progCfg);
    waitIdle();
    rdc("premature end", CTL, 32'h0000_00CC);
    rdc("abort status", IST, 32'h0000_0002);
    chk("irq masked", 0, irq);
    apb(1'b1, `FTA_OFF_IMASK, 32'h0000_0002);
    @(negedge ref_clk);
    chk("irq abort", 1, irq);
    abortNext <= 1'b0;
    setPtr(22'h00_0101);
    apb(1'b1, CTL, 32'h0000_0001);
    rdc("fetch bit", CTL, 32'h0000_0000);
    rdc("fetch latch", LAT, {24'h0, expByte(22'h00_0101)});
    apb(1'b1, CTL, 32'h0000_0082);
    chk("no enable", 3, nStart);
    // reset in mid cycle must drop the stall at once
    apb(1'b1, CTL, 32'h0000_0086);
    @(posedge ref_clk);
    resetn <= 1'b0;
    @(posedge ref_clk);
    resetn <= 1'b1;
    chk("stall reset", 0, coreStall);
    rdc("ctl reset", CTL, 32'h0000_0000);
    end_sim();
  end
endmodule
